/* File: verilog/i2c_kp_pkg.sv */
// Shared constants, types and helpers for the keypad controller two-wire port
package i2c_kp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clocking and timing
	localparam int unsigned MCLK_KHZ       = 100_000;
	localparam int unsigned TIMEOUT_MS     = 20;
	// Least time, so the count is exact here and never rounds down
	localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * MCLK_KHZ;
	localparam int unsigned SCL_KHZ        = 400;
	localparam int unsigned SCL_QUARTER    = (MCLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
	localparam logic [7:0]  SCL_QUARTER_M1 = 8'(SCL_QUARTER - 1);

	////////////////////////////////////////////////////////////////////////////
	// Slave address
	localparam logic [3:0] ADDR_HI = 4'h7;
	localparam logic       ADDR_A1 = 1'h0;
	localparam logic [1:0] SEL_GND = 2'h0;
	localparam logic [1:0] SEL_VCC = 2'h1;
	localparam logic [1:0] SEL_SDA = 2'h2;
	localparam logic [1:0] SEL_SCL = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Byte framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_NONE      = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Register pointer
	localparam logic [7:0] PTR_RESET     = 8'h00;
	localparam logic [7:0] PTR_FIFO      = 8'h00;
	localparam logic [7:0] PTR_AUTOSLEEP = 8'h06;
	localparam logic [7:0] KEY_FIRST     = 8'h01;
	localparam logic [7:0] KEY_LAST      = 8'h05;
	localparam logic [7:0] GPIO_FIRST    = 8'h30;
	localparam logic [7:0] GPIO_LAST     = 8'h5b;
	localparam logic [7:0] PTR_STEP      = 8'h01;
	localparam logic [7:0] TO_FLAG_ADDR  = 8'h48;

	////////////////////////////////////////////////////////////////////////////
	// Master command codes
	typedef enum logic [1:0] {
		hcmd_start,
		hcmd_write,
		hcmd_read,
		hcmd_stop
	} host_cmd_e;

	// Pointer step after each data byte; unlisted addresses hold
	function automatic logic [7:0] ptr_advance(input logic [7:0] p);
		if (p == PTR_AUTOSLEEP) begin
			return PTR_FIFO;
		end else if ((p >= KEY_FIRST && p <= KEY_LAST) || (p >= GPIO_FIRST && p <= GPIO_LAST)) begin
			return 8'(p + PTR_STEP);
		end else begin
			return p;
		end
	endfunction

endpackage

/* File: verilog/i2c_link.sv */
// Two-wire bus between master and slave, with wired-AND data line
`timescale 1ns/10ps
interface i2c_link;
	logic       scl;
	logic       sda_m_oe_n;
	logic       sda_s_oe_n;
	logic       sda;
	// Board strap for the address-select pin, set by the bench
	logic [1:0] addr_tie;
	logic       addr_select_pin;

	// Pull-up: line is low whenever any party enables its driver
	assign sda = sda_m_oe_n & sda_s_oe_n;
	assign addr_select_pin = (addr_tie == i2c_kp_pkg::SEL_GND) ? 1'h0 :
	                         (addr_tie == i2c_kp_pkg::SEL_VCC) ? 1'h1 :
	                         (addr_tie == i2c_kp_pkg::SEL_SDA) ? sda : scl;

	modport device (input scl, input sda, input addr_select_pin, output sda_s_oe_n);
	modport host (output scl, output sda_m_oe_n, input sda);
endinterface

/* File: verilog/line_sync.sv */
// Two-stage synchroniser with one extra stage for edge detection
`timescale 1ns/10ps
module line_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// Lines
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic      [W-1:0] q_prev
);
	logic [W-1:0] meta_reg;

	// Idle bus is high, so reset to ones to avoid false edges
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_reg <= '1;
			q        <= '1;
			q_prev   <= '1;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
			q_prev   <= q;
		end
	end
endmodule // line_sync

/* File: verilog/kp_i2c_slave.sv */
// Slave end of the keypad controller two-wire port with pointer and timeout
// Overview of operation
// R1 - Master starts transfers and makes the clock
// R2 - Clock is input only; data pulls low
// R3 - Start, address, command, data bytes, stop
// R4 - Start and stop are data edges, clock high
// R5 - One bit per clock, stable while high
// R6 - Receiver acknowledges on ninth clock, low
// R7 - Direction bit: low write, high read
// R8 - Upper address nibble is fixed 0111
// R9 - Strap to GND, VCC, SDA, SCL selects A3:A2
// R10 - Watch for start plus own address; acknowledge
// R11 - Clock edge gap over 20ms aborts transfer
// R12 - After timeout ignore bus until start
// R13 - Timeout switchable by a configuration bit
// R14 - First write byte becomes the register pointer
// R15 - Stop after command only keeps pointer
// R16 - First data byte goes to pointed register
// R17 - Later bytes follow the advancing pointer
// R18 - Timeout asserts shared interrupt until flag read
// R19 - Pointer advance follows fixed address table
// R20 - Reads start at pointer, advance per byte
// R21 - Sleep disables the bus timeout
// R22 - Master not-acknowledge releases data, waits
// R23 - Foreign address: stay released, pointer untouched
`timescale 1ns/10ps
module kp_i2c_slave #(
	parameter int unsigned TIMEOUT_CYCLES = i2c_kp_pkg::TIMEOUT_CYCLES
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// Bus pins
	i2c_link.device         link,
	// Configuration and power state
	input  wire logic       timeout_en,
	input  wire logic       sleep,
	// Other interrupt sources
	input  wire logic       key_int,
	input  wire logic       gpio_int,
	// Register file access
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata,
	// Shared interrupt
	output logic            int_n
);
	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_ack_addr,
		st_cmd,
		st_ack_cmd,
		st_wr,
		st_ack_wr,
		st_rd,
		st_ack_rd,
		st_ignore
	} st_e;

	st_e         state_reg;
	logic [3:0]  cnt_reg;
	logic [7:0]  shift_reg;
	logic        oe_n_reg;
	logic        rw_reg;
	logic        nack_reg;
	logic [7:0]  ptr_reg;
	logic        reg_wr_reg;
	logic        reg_rd_reg;
	logic [7:0]  reg_addr_reg;
	logic [7:0]  reg_wdata_reg;
	logic        flag_reg;
	logic        int_n_reg;
	logic [31:0] to_cnt_reg;
	logic        p_idle_reg;
	logic        p_start_reg;
	logic        p_low_reg;
	logic [2:0]  lines;
	logic [2:0]  lines_prev;

	////////////////////////////////////////////////////////////////////////////
	// Pin sampling and bus events

	line_sync #(.W(3)) u_sync (
		.mclk   (mclk),
		.reset  (reset),
		.d      ({link.scl, link.sda, link.addr_select_pin}),
		.q      (lines),
		.q_prev (lines_prev)
	);

	logic scl, scl_p, sda, sda_p, pin;
	assign scl   = lines[2];
	assign sda   = lines[1];
	assign pin   = lines[0];
	assign scl_p = lines_prev[2];
	assign sda_p = lines_prev[1];

	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl & ~scl_p;                       // [R1] [R5]
	assign scl_fall = ~scl & scl_p;
	assign start_ev = scl & scl_p & sda_p & ~sda;          // [R4]
	assign stop_ev  = scl & scl_p & ~sda_p & sda;          // [R4]

	////////////////////////////////////////////////////////////////////////////
	// Address strap decode

	logic [1:0] sel;
	always_comb begin
		if (!p_idle_reg) begin
			sel = i2c_kp_pkg::SEL_GND;
		end else if (!p_start_reg) begin
			sel = i2c_kp_pkg::SEL_SDA;
		end else if (!p_low_reg) begin
			sel = i2c_kp_pkg::SEL_SCL;
		end else begin
			sel = i2c_kp_pkg::SEL_VCC;
		end
	end

	// Strap tied to a bus line is told apart by when it follows that line
	always_ff @(posedge mclk) begin
		if (reset) begin
			p_idle_reg  <= 1'h1;
			p_start_reg <= 1'h1;
			p_low_reg   <= 1'h1;
		end else begin
			if (state_reg == st_idle && scl && sda) begin
				p_idle_reg <= pin;                            // [R9]
			end
			if (start_ev) begin
				p_start_reg <= pin;                           // [R9]
			end
			if (scl_fall && state_reg == st_addr && cnt_reg == i2c_kp_pkg::BIT_NONE) begin
				p_low_reg <= pin;                             // [R9]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timeout

	logic counting, timeout_hit;
	assign counting = timeout_en & ~sleep                    // [R13] [R21]
	                  & ~(state_reg inside {st_idle, st_ignore});
	assign timeout_hit = counting && to_cnt_reg == TIMEOUT_CYCLES;   // [R11]

	always_ff @(posedge mclk) begin
		if (reset || !counting || scl_rise || scl_fall) begin
			to_cnt_reg <= 32'h0000_0000;
		end else if (to_cnt_reg != TIMEOUT_CYCLES) begin
			to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte events

	logic quiet, byte_full, addr_match;
	logic cmd_ev, wr_ev, rd_done_ev, rd_load_ev;
	logic [7:0] tx_byte;
	assign quiet      = ~start_ev & ~stop_ev & ~timeout_hit;
	assign byte_full  = scl_fall & quiet & (cnt_reg == i2c_kp_pkg::BITS_PER_BYTE);
	assign addr_match = shift_reg[7:1] == {i2c_kp_pkg::ADDR_HI, sel, i2c_kp_pkg::ADDR_A1}; // [R8]
	assign cmd_ev     = byte_full & (state_reg == st_cmd);
	assign wr_ev      = byte_full & (state_reg == st_wr);
	assign rd_done_ev = byte_full & (state_reg == st_rd);
	assign rd_load_ev = scl_fall & quiet & ((state_reg == st_ack_addr & rw_reg)
	                    | (state_reg == st_ack_rd & ~nack_reg));
	// Flag is read from here; the rest of the map lives outside
	assign tx_byte    = (ptr_reg == i2c_kp_pkg::TO_FLAG_ADDR) ? {7'h00, flag_reg} : reg_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Protocol state machine

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= st_idle;
			cnt_reg   <= i2c_kp_pkg::BIT_NONE;
			shift_reg <= 8'h00;
			oe_n_reg  <= 1'h1;
			rw_reg    <= 1'h0;
			nack_reg  <= 1'h0;
		end else if (start_ev) begin
			state_reg <= st_addr;                             // [R10] [R12]
			cnt_reg   <= i2c_kp_pkg::BIT_NONE;
			oe_n_reg  <= 1'h1;
		end else if (stop_ev) begin
			state_reg <= st_idle;
			oe_n_reg  <= 1'h1;
		end else if (timeout_hit) begin
			state_reg <= st_ignore;                           // [R11] [R12]
			oe_n_reg  <= 1'h1;
		end else if (scl_rise) begin
			if (state_reg inside {st_addr, st_cmd, st_wr}) begin
				shift_reg <= {shift_reg[6:0], sda};           // [R3] [R5]
				cnt_reg   <= 4'(cnt_reg + 4'h1);
			end else if (state_reg == st_rd) begin
				cnt_reg   <= 4'(cnt_reg + 4'h1);
			end else if (state_reg == st_ack_rd) begin
				nack_reg  <= sda;                             // [R6]
			end
		end else if (rd_load_ev) begin
			shift_reg <= tx_byte;                             // [R20]
			oe_n_reg  <= tx_byte[7];                          // [R2]
			cnt_reg   <= i2c_kp_pkg::BIT_NONE;
			state_reg <= st_rd;
		end else if (scl_fall) begin
			unique case (state_reg)
				st_addr: begin
					if (cnt_reg == i2c_kp_pkg::BITS_PER_BYTE) begin
						if (addr_match) begin
							rw_reg    <= shift_reg[0];        // [R7]
							oe_n_reg  <= 1'h0;                // [R6] [R10]
							state_reg <= st_ack_addr;
						end else begin
							state_reg <= st_ignore;           // [R23]
						end
					end
				end
				st_cmd, st_wr: begin
					if (cnt_reg == i2c_kp_pkg::BITS_PER_BYTE) begin
						oe_n_reg  <= 1'h0;                    // [R6]
						state_reg <= (state_reg == st_cmd) ? st_ack_cmd : st_ack_wr;
					end
				end
				st_ack_addr, st_ack_cmd, st_ack_wr: begin
					oe_n_reg  <= 1'h1;
					cnt_reg   <= i2c_kp_pkg::BIT_NONE;
					state_reg <= (state_reg == st_ack_addr) ? st_cmd : st_wr;
				end
				st_rd: begin
					if (cnt_reg == i2c_kp_pkg::BITS_PER_BYTE) begin
						oe_n_reg  <= 1'h1;                    // [R6]
						state_reg <= st_ack_rd;
					end else begin
						shift_reg <= {shift_reg[6:0], 1'h0};
						oe_n_reg  <= shift_reg[6];            // [R5]
					end
				end
				st_ack_rd: begin
					state_reg <= st_ignore;                   // [R22]
				end
				st_idle, st_ignore: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register pointer

	always_ff @(posedge mclk) begin
		if (reset) begin
			ptr_reg <= i2c_kp_pkg::PTR_RESET;
		end else if (cmd_ev) begin
			ptr_reg <= shift_reg;                             // [R14] [R15]
		end else if (wr_ev || rd_done_ev) begin
			ptr_reg <= i2c_kp_pkg::ptr_advance(ptr_reg);      // [R17] [R19] [R20]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file strobes

	// Address trails the pointer by one cycle so a write sees the old pointer
	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_wr_reg    <= 1'h0;
			reg_rd_reg    <= 1'h0;
			reg_addr_reg  <= i2c_kp_pkg::PTR_RESET;
			reg_wdata_reg <= 8'h00;
		end else begin
			reg_wr_reg   <= wr_ev;                            // [R16] [R17]
			reg_rd_reg   <= rd_load_ev;
			reg_addr_reg <= ptr_reg;
			if (wr_ev) begin
				reg_wdata_reg <= shift_reg;                   // [R16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timeout flag and interrupt

	always_ff @(posedge mclk) begin
		if (reset) begin
			flag_reg  <= 1'h0;
			int_n_reg <= 1'h1;
		end else begin
			// A timeout in the clearing cycle still sets the flag
			if (timeout_hit) begin
				flag_reg <= 1'h1;                             // [R18]
			end else if (rd_load_ev && ptr_reg == i2c_kp_pkg::TO_FLAG_ADDR) begin
				flag_reg <= 1'h0;                             // [R18]
			end
			int_n_reg <= ~(flag_reg | key_int | gpio_int);   // [R18]
		end
	end

	assign link.sda_s_oe_n = oe_n_reg;                       // [R2]
	assign reg_wr          = reg_wr_reg;
	assign reg_rd          = reg_rd_reg;
	assign reg_addr        = reg_addr_reg;
	assign reg_wdata       = reg_wdata_reg;
	assign int_n           = int_n_reg;
endmodule // kp_i2c_slave

/* File: verilog/kp_i2c_master.sv */
// Master end: byte-level command port driving the two-wire bus
`timescale 1ns/10ps
module kp_i2c_master (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  reset,
	// Bus pins
	i2c_link.host                      link,
	// Command port
	input  wire logic                  cmd_valid,
	input  wire i2c_kp_pkg::host_cmd_e cmd_code,
	input  wire logic [7:0]            cmd_data,
	input  wire logic                  cmd_last,
	output logic                       cmd_ready,
	// Response port
	output logic                       rsp_valid,
	output logic [7:0]                 rsp_data,
	output logic                       rsp_nack
);
	typedef enum logic [1:0] {
		h_idle,
		h_start,
		h_byte,
		h_stop
	} h_st_e;

	h_st_e      state_reg;
	logic [7:0] q_cnt_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic       rd_reg;
	logic       last_reg;
	logic       ack_reg;
	logic       scl_reg;
	logic       oe_n_reg;
	logic       ready_reg;
	logic       rsp_valid_reg;
	logic [7:0] rsp_data_reg;
	logic       rsp_nack_reg;
	logic       sda;
	logic       tick;

	line_sync #(.W(1)) u_sync (
		.mclk   (mclk),
		.reset  (reset),
		.d      (link.sda),
		.q      (sda),
		.q_prev ()
	);

	////////////////////////////////////////////////////////////////////////////
	// Quarter-period divider, runs only while a command is in flight

	assign tick = (q_cnt_reg == i2c_kp_pkg::SCL_QUARTER_M1);

	always_ff @(posedge mclk) begin
		if (reset || state_reg == h_idle || tick) begin
			q_cnt_reg <= 8'h00;
		end else begin
			q_cnt_reg <= 8'(q_cnt_reg + 8'h01);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer; data changes only while the clock is low, except the start and stop edges made with the clock high

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg     <= h_idle;
			phase_reg     <= 2'h0;
			bit_reg       <= 4'h0;
			sh_reg        <= 8'h00;
			rd_reg        <= 1'h0;
			last_reg      <= 1'h0;
			ack_reg       <= 1'h1;
			scl_reg       <= 1'h1;
			oe_n_reg      <= 1'h1;
			ready_reg     <= 1'h1;
			rsp_valid_reg <= 1'h0;
			rsp_data_reg  <= 8'h00;
			rsp_nack_reg  <= 1'h0;
		end else begin
			rsp_valid_reg <= 1'h0;
			if (state_reg == h_idle) begin
				if (cmd_valid && ready_reg) begin
					ready_reg <= 1'h0;
					phase_reg <= 2'h0;
					bit_reg   <= 4'h0;
					sh_reg    <= cmd_data;
					rd_reg    <= (cmd_code == i2c_kp_pkg::hcmd_read);
					last_reg  <= cmd_last;
					unique case (cmd_code)
						i2c_kp_pkg::hcmd_start: state_reg <= h_start;
						i2c_kp_pkg::hcmd_write,
						i2c_kp_pkg::hcmd_read:  state_reg <= h_byte;
						i2c_kp_pkg::hcmd_stop:  state_reg <= h_stop;
					endcase
				end
			end else if (tick) begin
				phase_reg <= 2'(phase_reg + 2'h1);
				unique case (state_reg)
					h_start: begin
						unique case (phase_reg)
							2'h0: oe_n_reg <= 1'h1;
							2'h1: scl_reg  <= 1'h1;
							2'h2: oe_n_reg <= 1'h0;           // [R4]
							2'h3: begin
								scl_reg   <= 1'h0;
								state_reg <= h_idle;
								ready_reg <= 1'h1;
							end
						endcase
					end
					h_byte: begin
						unique case (phase_reg)
							2'h0: begin
								if (bit_reg == i2c_kp_pkg::BITS_PER_BYTE) begin
									oe_n_reg <= rd_reg ? last_reg : 1'h1;   // [R6]
								end else begin
									oe_n_reg <= rd_reg ? 1'h1 : sh_reg[7];  // [R5]
								end
							end
							2'h1: scl_reg <= 1'h1;            // [R1]
							2'h2: begin
								if (bit_reg == i2c_kp_pkg::BITS_PER_BYTE) begin
									ack_reg <= sda;
								end else begin
									sh_reg  <= {sh_reg[6:0], sda};
								end
							end
							2'h3: begin
								scl_reg <= 1'h0;
								if (bit_reg == i2c_kp_pkg::BITS_PER_BYTE) begin
									state_reg     <= h_idle;
									ready_reg     <= 1'h1;
									rsp_valid_reg <= 1'h1;
									rsp_data_reg  <= sh_reg;
									rsp_nack_reg  <= ack_reg;
								end else begin
									bit_reg <= 4'(bit_reg + 4'h1);
								end
							end
						endcase
					end
					h_stop: begin
						unique case (phase_reg)
							2'h0: oe_n_reg <= 1'h0;
							2'h1: scl_reg  <= 1'h1;
							2'h2: oe_n_reg <= 1'h1;           // [R4]
							2'h3: begin
								state_reg <= h_idle;
								ready_reg <= 1'h1;
							end
						endcase
					end
					h_idle: begin
					end
				endcase
			end
		end
	end

	assign link.scl        = scl_reg;
	assign link.sda_m_oe_n = oe_n_reg;
	assign cmd_ready       = ready_reg;
	assign rsp_valid       = rsp_valid_reg;
	assign rsp_data        = rsp_data_reg;
	assign rsp_nack        = rsp_nack_reg;
endmodule // kp_i2c_master

/* File: tb/kp_i2c_asserts.sv */
// Concurrent checks on the two-wire link and the slave's side outputs
`timescale 1ns/10ps
module kp_i2c_asserts #(
	parameter int unsigned TIMEOUT_CYCLES = i2c_kp_pkg::TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_oe_n,
	input wire logic sda_s_oe_n,
	// Slave side
	input wire logic timeout_en,
	input wire logic sleep,
	input wire logic key_int,
	input wire logic gpio_int,
	input wire logic reg_wr,
	input wire logic int_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	logic        scl_q;
	logic [31:0] hold_cnt;

	always_ff @(posedge mclk) begin
		scl_q <= scl;
	end

	// Raw pins lead the slave's synchroniser, hence the margin below
	always_ff @(posedge mclk) begin
		if (reset || scl != scl_q || sda_s_oe_n || !timeout_en || sleep) begin
			hold_cnt <= 32'h0000_0000;
		end else begin
			hold_cnt <= hold_cnt + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////
	a_master_reset_idle: assert property ($fell(reset) |-> scl && sda_m_oe_n)
		else $error("master not idle after reset");
	a_slave_reset_free: assert property ($fell(reset) |-> sda_s_oe_n)
		else $error("slave drives data after reset");
	a_master_bit_hold: assert property ($rose(scl) |-> $stable(sda_m_oe_n) [*8])
		else $error("master data moved in clock high");
	a_slave_bit_hold: assert property ($rose(scl) |-> $stable(sda_s_oe_n) [*8])
		else $error("slave data moved in clock high");
	a_slave_move_low: assert property ($changed(sda_s_oe_n) |-> !scl)
		else $error("slave data changed with clock high");
	a_stop_frees: assert property (scl && $rose(sda) |-> ##1 sda_s_oe_n [*8])
		else $error("slave drives data after stop");
	a_int_source: assert property ((key_int || gpio_int) |=> !int_n)
		else $error("interrupt missing for source");
	a_int_cause: assert property ($fell(int_n) |-> $past(key_int) || $past(gpio_int)
		|| ($past(timeout_en, 3) && !$past(sleep, 3)))
		else $error("interrupt without cause");
	a_timeout_abort: assert property (hold_cnt < TIMEOUT_CYCLES + 16)
		else $error("slave held data past timeout");
	a_timeout_quiet: assert property ($fell(int_n) && !$past(key_int) && !$past(gpio_int)
		|-> sda_s_oe_n [*8])
		else $error("slave active after timeout");
	a_wr_single: assert property (reg_wr |=> !reg_wr [*8])
		else $error("write strobes too close");
endmodule // kp_i2c_asserts

/* File: tb/keypad_ctrl_i2c_slave_port_tb.sv */
// Self-checking bench: master and slave ends joined on one link
`timescale 1ns/10ps
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("wrong value at %0t: %h expected %h", $time, (g), (e)); \
	end \
end
module keypad_ctrl_i2c_slave_port_tb;
	localparam int unsigned TO = 3000;
	localparam i2c_kp_pkg::host_cmd_e START = i2c_kp_pkg::hcmd_start;
	localparam i2c_kp_pkg::host_cmd_e STOP  = i2c_kp_pkg::hcmd_stop;
	logic                  mclk       = 1'h0;
	logic                  reset      = 1'h1;
	logic                  cmd_valid  = 1'h0;
	i2c_kp_pkg::host_cmd_e cmd_code   = START;
	logic [7:0]            cmd_data   = 8'h00;
	logic                  cmd_last   = 1'h0;
	logic                  timeout_en = 1'h0;
	logic                  sleep      = 1'h0;
	logic                  key_int    = 1'h0;
	logic                  gpio_int   = 1'h0;
	logic                  cmd_ready, rsp_valid, rsp_nack, reg_wr, reg_rd, int_n;
	logic [7:0]            rsp_data, reg_addr, reg_wdata, reg_rdata, p, q;
	logic [7:0]            mem [256];
	logic [7:0]            d [4];
	logic [31:0]           seed       = 32'h0001_82ae;
	int                    fails      = 0;
	int                    n_compared = 0;
	int                    n_wr       = 0;
	int                    n_rd       = 0;
	int                    n_rsp      = 0;
	int                    n_bytes    = 0;

	i2c_link link ();
	kp_i2c_slave #(.TIMEOUT_CYCLES(TO)) i_kp_i2c_slave (
		.mclk(mclk), .reset(reset), .link(link), .timeout_en(timeout_en), .sleep(sleep),
		.key_int(key_int), .gpio_int(gpio_int), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_n(int_n));
	kp_i2c_master i_kp_i2c_master (
		.mclk(mclk), .reset(reset), .link(link), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_last(cmd_last),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
	kp_i2c_asserts #(.TIMEOUT_CYCLES(TO)) i_kp_i2c_asserts (
		.mclk(mclk), .reset(reset), .scl(link.scl), .sda(link.sda),
		.sda_m_oe_n(link.sda_m_oe_n), .sda_s_oe_n(link.sda_s_oe_n),
		.timeout_en(timeout_en), .sleep(sleep), .key_int(key_int),
		.gpio_int(gpio_int), .reg_wr(reg_wr), .int_n(int_n));

	// Register file behind the pointer
	assign reg_rdata = mem[reg_addr];
	always @(posedge mclk) begin
		if (reg_wr) begin
			mem[reg_addr] <= reg_wdata;
			n_wr++;
		end
		if (reg_rd) begin
			n_rd++;
		end
		if (rsp_valid) begin
			n_rsp++;
		end
	end

	initial begin
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] sa(input logic [1:0] t, input logic rw);
		return {4'h7, t, 1'h0, rw};
	endfunction

	function automatic logic [7:0] nxt(input logic [7:0] a);
		if (a == 8'h06) begin
			return 8'h00;
		end
		if ((a >= 8'h01 && a <= 8'h05) || (a >= 8'h30 && a <= 8'h5b)) begin
			return a + 8'h01;
		end
		return a;
	endfunction

	// Returns on a clock edge so callers drive on edges too
	task automatic cmd(input i2c_kp_pkg::host_cmd_e c, input logic [7:0] v, input logic last);
		int k;
		k = 0;
		@(posedge mclk);
		cmd_valid <= 1'h1;
		cmd_code  <= c;
		cmd_data  <= v;
		cmd_last  <= last;
		@(posedge mclk);
		cmd_valid <= 1'h0;
		#1;
		while (cmd_ready !== 1'h1 && k < 3000) begin
			@(posedge mclk);
			#1;
			k++;
		end
		if (k == 3000) begin
			fails++;
			finish_test();
		end
		@(posedge mclk);
	endtask

	task automatic bus(input i2c_kp_pkg::host_cmd_e c);
		cmd(c, 8'h00, 1'h0);
	endtask

	task automatic wb(input logic [7:0] v, input logic nack);
		cmd(i2c_kp_pkg::hcmd_write, v, 1'h0);
		n_bytes++;
		`CHK(rsp_nack, nack)
	endtask

	task automatic rb(input logic last, input logic [7:0] e);
		cmd(i2c_kp_pkg::hcmd_read, 8'h00, last);
		n_bytes++;
		`CHK(rsp_data, e)
	endtask

	task finish_test();
		if (fails == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 256; i++) begin
			seed = lfsr(seed);
			mem[i] = seed[7:0];
		end
		// Low first bit keeps the slave pulling data low when hung
		mem[8'h3f] = 8'h2a;
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			d[i] = seed[15:8];
		end
		link.addr_tie <= 2'h0;
		repeat (4) @(posedge mclk);
		reset <= 1'h0;
		repeat (8) @(posedge mclk);
		for (int t = 0; t < 4; t++) begin
			link.addr_tie <= 2'(t);
			repeat (8) @(posedge mclk);
			bus(START);
			wb(sa(2'(t), 1'h0), 1'h0);
			wb(8'h40 + 8'(t), 1'h0);
			bus(STOP);
		end
		`CHK(n_wr, 0)
		bus(START);
		wb(sa(2'h3, 1'h1), 1'h0);
		rb(1'h1, mem[8'h43]);
		bus(STOP);
		link.addr_tie <= 2'h0;
		repeat (8) @(posedge mclk);
		bus(START);
		wb(sa(2'h1, 1'h0), 1'h1);
		bus(STOP);
		for (int b = 0; b < 2; b++) begin
			p = b ? 8'h05 : 8'h30;
			bus(START);
			wb(sa(2'h0, 1'h0), 1'h0);
			wb(p, 1'h0);
			wb(d[2 * b], 1'h0);
			wb(d[2 * b + 1], 1'h0);
			bus(START);
			wb(sa(2'h0, 1'h1), 1'h0);
			q = nxt(nxt(p));
			rb(1'h0, mem[q]);
			rb(1'h1, mem[nxt(q)]);
			bus(STOP);
			`CHK(mem[p], d[2 * b])
			`CHK(mem[nxt(p)], d[2 * b + 1])
		end
		// Clock stuck low in mid-read
		timeout_en <= 1'h1;
		bus(START);
		wb(sa(2'h0, 1'h0), 1'h0);
		wb(8'h3f, 1'h0);
		bus(STOP);
		bus(START);
		wb(sa(2'h0, 1'h1), 1'h0);
		repeat (TO + 300) @(posedge mclk);
		`CHK(int_n, 1'h0)
		`CHK(link.sda_s_oe_n, 1'h1)
		wb(sa(2'h0, 1'h0), 1'h1);
		bus(START);
		wb(sa(2'h0, 1'h0), 1'h0);
		wb(8'h48, 1'h0);
		bus(START);
		wb(sa(2'h0, 1'h1), 1'h0);
		rb(1'h1, 8'h01);
		bus(STOP);
		repeat (3) @(posedge mclk);
		`CHK(int_n, 1'h1)
		sleep <= 1'h1;
		bus(START);
		wb(sa(2'h0, 1'h0), 1'h0);
		repeat (TO + 300) @(posedge mclk);
		`CHK(int_n, 1'h1)
		wb(8'h44, 1'h0);
		bus(STOP);
		sleep <= 1'h0;
		for (int v = 0; v < 4; v++) begin
			key_int  <= v[0];
			gpio_int <= v[1];
			repeat (3) @(posedge mclk);
			`CHK(int_n, ~(v[0] | v[1]))
		end
		// One load per read address, one more per acknowledged read byte
		`CHK(n_rd, 7)
		`CHK(n_rsp, n_bytes)
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge mclk);
		fails++;
		finish_test();
	end
endmodule // keypad_ctrl_i2c_slave_port_tb
